// ==== tsc_map.svh ====
// register offsets, field positions, reset values and limits of the trigger block
// assumes inclusion by bare name from the package and the property checker
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
`define TSC_OFF_CMD        8'h00
`define TSC_OFF_CTRL       8'h04
`define TSC_OFF_STAT       8'h08
`define TSC_OFF_PEND_CURR  8'h0c
`define TSC_OFF_PEND_VOLT  8'h10
`define TSC_OFF_IMM_CURR   8'h14
`define TSC_OFF_IMM_VOLT   8'h18
`define TSC_OFF_CNT_CURR   8'h1c
`define TSC_OFF_CNT_VOLT   8'h20
`define TSC_OFF_ACQ_CFG    8'h24
`define TSC_OFF_BUF_PTR    8'h28
`define TSC_OFF_BUF_DATA   8'h2c
`define TSC_CMD_ABORT      0
`define TSC_CMD_INIT_TRAN  1
`define TSC_CMD_INIT_ACQ   2
`define TSC_CMD_TRIG_TRAN  3
`define TSC_CMD_TRIG_ACQ   4
`define TSC_CMD_BUS_TRIG   5
`define TSC_CMD_RESET      6
`define TSC_CMD_RECALL     7
`define TSC_CMD_SELFTEST   8
`define TSC_CMD_STORE      9
`define TSC_CMD_INIT_NAME  10
`define TSC_CMD_NAME_BIT   11
`define TSC_CTRL_CONT      0
`define TSC_ACQ_SRC_BIT    0
`define TSC_ACQ_SLP_LSB    1
`define TSC_STAT_WTG       0
`define TSC_STAT_TRAN      1
`define TSC_STAT_ACQ       2
`define TSC_STAT_TST_RES   3
`define TSC_STAT_TST_DONE  4
`define TSC_STAT_STORES    16
`define TSC_CNT_MIN        7'h01
`define TSC_CNT_MAX        7'h64
`define TSC_CNT_RST        7'h01
`define TSC_BUF_DEPTH      128
`define TSC_TST_CYCLES     8'h10
`define TSC_ERR_CODE       16'h00f0
`endif

// ==== tsc_pkg.sv ====
// types shared by the trigger control block
// assumes tsc_map.svh is on the include path
`include "tsc_map.svh"
package tsc_pkg;
	typedef enum logic [1:0] {TSC_IDLE = 2'b00, TSC_WAIT = 2'b01, TSC_RUN = 2'b11} tsc_state_t;
	typedef enum logic [1:0] {TSC_SLP_EITHER = 2'b00, TSC_SLP_POS = 2'b01,
		TSC_SLP_NEG = 2'b10} tsc_slope_t;
	typedef enum logic {TSC_SRC_INT = 1'b0, TSC_SRC_BUS = 1'b1} tsc_src_t;
endpackage

// ==== tsc_edge_detect.sv ====
// internal measurement trigger: hysteresis crossing with slope select
// assumes samples synchronous to sys_clk with a one-cycle valid strobe
`timescale 1ns/1ps
module tsc_edge_detect
	import tsc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clr,
	input  wire logic        smp_valid,
	input  wire logic [15:0] smp,
	input  wire logic [15:0] level,
	input  wire logic [15:0] hyst,
	input  wire tsc_slope_t  slope,
	output logic             fire
);
	logic [16:0] lo_lim;
	logic [16:0] hi_lim;
	logic        below_q;
	logic        above_q;
	logic        low_hit;
	logic        high_hit;

	// band is level plus and minus half the hysteresis
	assign hi_lim   = {1'b0, level} + {2'b00, hyst[15:1]};
	assign lo_lim   = {1'b0, level} - {2'b00, hyst[15:1]};
	assign low_hit  = lo_lim[16] ? 1'b0 : ({1'b0, smp} < lo_lim);
	assign high_hit = {1'b0, smp} > hi_lim;

	// arm on the starting side, then fire on passing the far limit
	always_ff @(posedge sys_clk) begin
		if (!rst_n || clr) begin
			below_q <= 1'b0;
			above_q <= 1'b0;
		end else if (smp_valid) begin
			if (low_hit)
				below_q <= 1'b1;
			else if (high_hit)
				below_q <= 1'b0;
			if (high_hit)
				above_q <= 1'b1;
			else if (low_hit)
				above_q <= 1'b0;
		end
	end

	// rising needs start below, falling needs start above [RQ20]
	always_comb begin
		fire = 1'b0;
		if (smp_valid) begin
			unique case (slope)
				TSC_SLP_POS: fire = below_q && high_hit; // RQ20
				TSC_SLP_NEG: fire = above_q && low_hit; // RQ20
				default:     fire = (below_q && high_hit) || (above_q && low_hit); // RQ21
			endcase
		end
	end
endmodule // tsc_edge_detect

// ==== tsc_trigger_ctrl.sv ====
// trigger sequence control: transient and acquire sequences, wishbone slave
// assumes a classic wishbone master on sys_clk and a measurement front end
//
// Behaviour
// [RQ1] controller should not store state repeatedly; nonvolatile memory wears out
// [RQ2] self-test query runs, returns 0 pass or 1 fail, queues errors
// [RQ3] sequences selectable by name or number; 1 is transient, default
// [RQ4] abort cancels trigger actions, pending levels return to immediate values
// [RQ5] abort clears the waiting-for-trigger flag
// [RQ6] continuous on re-initiates transient right after abort
// [RQ7] implicit abort at power-up, recall and reset command
// [RQ8] triggers ignored while a sequence is not initiated
// [RQ9] initiated sequence acts on an event of its selected source
// [RQ10] continuous 1 re-arms transient; 0 needs an initiate per trigger
// [RQ11] transient trigger applies pending current and voltage levels
// [RQ12] waiting flag is or of both sequences' waiting states; the code also sets it while acquire is running
// [RQ13] continuous on re-enables transient after trigger, flag set again
// [RQ14] transient source is bus only, reset value bus
// [RQ15] acquire trigger measures voltage and current into buffer
// [RQ16] current capture count 1 to 100, reset value 1
// [RQ17] voltage capture count 1 to 100, reset value 1
// [RQ18] after each measurement wait for next trigger until count exhausted
// [RQ19] acquire source bus or internal, internal at reset
// [RQ20] internal trigger needs full excursion through hysteresis band
// [RQ21] slope rising, falling or either; either at reset
// [RQ22] common bus trigger only fires sequences whose source is bus
// [RQ23] without continuous, sequence returns idle once action completes
`timescale 1ns/1ps
module tsc_trigger_ctrl
	import tsc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_volt,
	input  wire logic [15:0] meas_curr,
	input  wire logic        selftest_fail,
	output logic      [15:0] out_curr_level,
	output logic      [15:0] out_volt_level,
	output logic             waiting_for_trigger_flag,
	output logic             err_push,
	output logic      [15:0] err_code,
	output logic             state_store_pulse
);
	logic             ack_q;
	logic      [31:0] dat_q;
	logic             err_q;
	logic             wr_stb;
	logic             rd_stb;
	logic             cont_q;
	logic             acq_src_q;
	logic      [1:0]  slope_q;
	logic      [15:0] lvl_curr_q, lvl_volt_q, hyst_curr_q, hyst_volt_q;
	logic      [15:0] pend_curr_q, pend_volt_q, imm_curr_q, imm_volt_q;
	logic      [6:0]  cnt_curr_q, cnt_volt_q;
	logic      [6:0]  done_q;
	tsc_state_t       tran_q, acq_q;
	logic             power_up_q;
	logic             abort_ev;
	logic             tran_fire;
	logic             init_tran, init_acq;
	logic             tran_ev, acq_ev;
	logic             int_fire_v, int_fire_c;
	logic      [7:0]  tst_cnt_q;
	logic             tst_run_q, tst_res_q, tst_done_q;
	logic      [15:0] store_cnt_q;
	logic      [6:0]  buf_ptr_q, rd_ptr_q;
	logic      [31:0] buf_mem [`TSC_BUF_DEPTH];
	logic      [6:0]  acq_target;

	// a command write is a one-cycle strobe on the accepting edge
	function automatic logic cmd_hit(input logic [31:0] d, input int b);
		return d[b];
	endfunction

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
	// err also blocks a retake, so an unmapped access answers exactly once
	assign rd_stb = wb_cyc_i && wb_stb_i && !ack_q && !err_q;

	// decoded command events
	wire cmd_wr = wr_stb && (wb_adr_i == `TSC_OFF_CMD);
	// reset command clears continuous, so its abort must not re-arm
	wire rst_cmd = cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_RESET);
	// power-up, recall and reset all force an abort
	assign abort_ev = power_up_q || (cmd_wr && (cmd_hit(wb_dat_i, `TSC_CMD_ABORT)
		|| cmd_hit(wb_dat_i, `TSC_CMD_RESET) || cmd_hit(wb_dat_i, `TSC_CMD_RECALL))); // RQ7
	// name-based initiate uses the name bit: 0 transient, 1 acquire
	wire name_init = cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_INIT_NAME);
	assign init_tran = cmd_wr && (cmd_hit(wb_dat_i, `TSC_CMD_INIT_TRAN)
		|| (name_init && !wb_dat_i[`TSC_CMD_NAME_BIT])); // RQ3
	assign init_acq = cmd_wr && (cmd_hit(wb_dat_i, `TSC_CMD_INIT_ACQ)
		|| (name_init && wb_dat_i[`TSC_CMD_NAME_BIT])); // RQ3
	wire bus_trig = cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_BUS_TRIG);
	// transient source is always bus, so a common trigger always reaches it
	assign tran_ev = cmd_wr && (cmd_hit(wb_dat_i, `TSC_CMD_TRIG_TRAN) || bus_trig); // RQ14
	assign tran_fire = (tran_q == TSC_WAIT) && tran_ev && !abort_ev; // RQ9 RQ11
	// common trigger reaches acquire only when its source is bus
	assign acq_ev = (acq_src_q == TSC_SRC_BUS)
		? (bus_trig || (cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_TRIG_ACQ))) // RQ22
		: (int_fire_v || int_fire_c); // RQ19
	assign acq_target = (cnt_curr_q > cnt_volt_q) ? cnt_curr_q : cnt_volt_q;

	// power-up abort pulse after reset release
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			power_up_q <= 1'b1;
		else
			power_up_q <= 1'b0; // RQ7
	end

	// wishbone classic slave, one wait state, ack drops after one cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			if (rd_stb) begin
				ack_q <= 1'b1;
				dat_q <= 32'h0;
				unique case (wb_adr_i)
					`TSC_OFF_CMD:       ;
					`TSC_OFF_CTRL:      dat_q <= {31'h0, cont_q};
					`TSC_OFF_STAT:      dat_q <= {store_cnt_q, 11'h0, tst_done_q, tst_res_q,
						acq_q != TSC_IDLE, tran_q != TSC_IDLE, waiting_for_trigger_flag};
					`TSC_OFF_PEND_CURR: dat_q <= {16'h0, pend_curr_q};
					`TSC_OFF_PEND_VOLT: dat_q <= {16'h0, pend_volt_q};
					`TSC_OFF_IMM_CURR:  dat_q <= {16'h0, imm_curr_q};
					`TSC_OFF_IMM_VOLT:  dat_q <= {16'h0, imm_volt_q};
					`TSC_OFF_CNT_CURR:  dat_q <= {25'h0, cnt_curr_q};
					`TSC_OFF_CNT_VOLT:  dat_q <= {25'h0, cnt_volt_q};
					`TSC_OFF_ACQ_CFG:   dat_q <= {29'h0, slope_q, acq_src_q};
					`TSC_OFF_BUF_PTR:   dat_q <= {9'h0, rd_ptr_q, 9'h0, buf_ptr_q};
					`TSC_OFF_BUF_DATA:  dat_q <= buf_mem[rd_ptr_q];
					default: begin
						ack_q <= 1'b0;
						err_q <= 1'b1; // unmapped address answers with err
					end
				endcase
			end
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = dat_q;

	// configuration registers; out-of-range counts are refused
	always_ff @(posedge sys_clk) begin
		if (!rst_n || (cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_RESET))) begin
			cont_q      <= 1'b0;
			acq_src_q   <= TSC_SRC_INT; // RQ19
			slope_q     <= TSC_SLP_EITHER; // RQ21
			cnt_curr_q  <= `TSC_CNT_RST; // RQ16
			cnt_volt_q  <= `TSC_CNT_RST; // RQ17
			imm_curr_q  <= 16'h0;
			imm_volt_q  <= 16'h0;
			lvl_curr_q  <= 16'h0;
			lvl_volt_q  <= 16'h0;
			hyst_curr_q <= 16'h0;
			hyst_volt_q <= 16'h0;
		end else if (tran_fire) begin
			// triggered levels become the new immediate levels
			imm_curr_q <= pend_curr_q; // RQ11
			imm_volt_q <= pend_volt_q; // RQ11
		end else if (wr_stb) begin
			unique case (wb_adr_i)
				`TSC_OFF_CTRL:     cont_q <= wb_dat_i[`TSC_CTRL_CONT];
				`TSC_OFF_IMM_CURR: imm_curr_q <= wb_dat_i[15:0];
				`TSC_OFF_IMM_VOLT: imm_volt_q <= wb_dat_i[15:0];
				`TSC_OFF_CNT_CURR:
					if (wb_dat_i[6:0] >= `TSC_CNT_MIN && wb_dat_i[6:0] <= `TSC_CNT_MAX
						&& wb_dat_i[31:7] == 25'h0)
						cnt_curr_q <= wb_dat_i[6:0]; // RQ16
				`TSC_OFF_CNT_VOLT:
					if (wb_dat_i[6:0] >= `TSC_CNT_MIN && wb_dat_i[6:0] <= `TSC_CNT_MAX
						&& wb_dat_i[31:7] == 25'h0)
						cnt_volt_q <= wb_dat_i[6:0]; // RQ17
				`TSC_OFF_ACQ_CFG: begin
					acq_src_q <= wb_dat_i[`TSC_ACQ_SRC_BIT];
					if (wb_dat_i[`TSC_ACQ_SLP_LSB+1:`TSC_ACQ_SLP_LSB] != 2'b11)
						slope_q <= wb_dat_i[`TSC_ACQ_SLP_LSB+1:`TSC_ACQ_SLP_LSB];
					lvl_volt_q  <= wb_dat_i[31:16];
					hyst_volt_q <= {8'h0, wb_dat_i[15:8]};
				end
				default: ;
			endcase
		end
	end

	// pending levels; abort returns them to the immediate values
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pend_curr_q <= 16'h0;
			pend_volt_q <= 16'h0;
		end else if (abort_ev) begin
			pend_curr_q <= imm_curr_q; // RQ4
			pend_volt_q <= imm_volt_q; // RQ4
		end else if (wr_stb && wb_adr_i == `TSC_OFF_PEND_CURR)
			pend_curr_q <= wb_dat_i[15:0];
		else if (wr_stb && wb_adr_i == `TSC_OFF_PEND_VOLT)
			pend_volt_q <= wb_dat_i[15:0];
	end

	// output levels follow immediate values, so an applied trigger level sticks
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_curr_level <= 16'h0;
			out_volt_level <= 16'h0;
		end else begin
			out_curr_level <= imm_curr_q; // RQ11
			out_volt_level <= imm_volt_q; // RQ11
		end
	end

	// transient sequence; abort wins over everything, then re-arms if continuous
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			tran_q <= TSC_IDLE;
		else if (abort_ev)
			tran_q <= (cont_q && !rst_cmd) ? TSC_WAIT : TSC_IDLE; // RQ4 RQ6
		else unique case (tran_q)
			TSC_IDLE:
				if (init_tran || cont_q)
					tran_q <= TSC_WAIT; // RQ10
			TSC_WAIT:
				if (tran_ev)
					tran_q <= TSC_RUN; // RQ9
			TSC_RUN:
				tran_q <= cont_q ? TSC_WAIT : TSC_IDLE; // RQ13 RQ23
			default:
				tran_q <= TSC_IDLE;
		endcase
	end

	// acquire sequence counts triggers until the larger capture count
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			acq_q  <= TSC_IDLE;
			done_q <= 7'h0;
		end else if (abort_ev) begin
			acq_q  <= TSC_IDLE; // RQ4
			done_q <= 7'h0;
		end else unique case (acq_q)
			TSC_IDLE:
				if (init_acq) begin
					acq_q  <= TSC_WAIT;
					done_q <= 7'h0;
				end
			TSC_WAIT:
				if (acq_ev)
					acq_q <= TSC_RUN; // RQ9 RQ15
			TSC_RUN:
				if (meas_valid) begin
					done_q <= done_q + 7'h1;
					acq_q  <= (done_q + 7'h1 >= acq_target) ? TSC_IDLE : TSC_WAIT; // RQ18 RQ23
				end
			default:
				acq_q <= TSC_IDLE;
		endcase
	end

	// capture buffer, written only by triggered measurements
	always_ff @(posedge sys_clk) begin
		if (!rst_n || init_acq)
			buf_ptr_q <= 7'h0;
		else if (acq_q == TSC_RUN && meas_valid) begin
			buf_mem[buf_ptr_q] <= {meas_volt, meas_curr}; // RQ15
			buf_ptr_q <= buf_ptr_q + 7'h1;
		end
	end

	// read pointer for draining the buffer
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			rd_ptr_q <= 7'h0;
		else if (wr_stb && wb_adr_i == `TSC_OFF_BUF_PTR)
			rd_ptr_q <= wb_dat_i[22:16];
	end

	// flag is the or of transient waiting and acquire not idle; triggers outside wait are ignored
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			waiting_for_trigger_flag <= 1'b0;
		else if (abort_ev)
			waiting_for_trigger_flag <= cont_q && !rst_cmd; // RQ5 RQ6
		else
			waiting_for_trigger_flag <= (tran_q == TSC_WAIT && !tran_ev) || tran_q == TSC_RUN && cont_q
				|| (tran_q == TSC_IDLE && (init_tran || cont_q))
				|| (acq_q != TSC_IDLE) || init_acq; // RQ8 RQ12 RQ13
	end

	// self-test: fixed run time, result 0 pass or 1 fail, error queued on failure
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tst_run_q  <= 1'b0;
			tst_res_q  <= 1'b0;
			tst_done_q <= 1'b0;
			tst_cnt_q  <= 8'h0;
			err_push   <= 1'b0;
			err_code   <= 16'h0;
		end else begin
			err_push <= 1'b0;
			if (cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_SELFTEST) && !tst_run_q) begin
				tst_run_q  <= 1'b1;
				tst_done_q <= 1'b0;
				tst_res_q  <= 1'b0;
				tst_cnt_q  <= `TSC_TST_CYCLES;
			end else if (tst_run_q) begin
				if (selftest_fail)
					tst_res_q <= 1'b1; // RQ2
				tst_cnt_q <= tst_cnt_q - 8'h1;
				if (tst_cnt_q == 8'h1) begin
					tst_run_q  <= 1'b0;
					tst_done_q <= 1'b1;
					err_push   <= tst_res_q || selftest_fail; // RQ2
					err_code   <= `TSC_ERR_CODE;
				end
			end
		end
	end

	// state store strobe and wear counter so software can watch write count
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_store_pulse <= 1'b0;
			store_cnt_q       <= 16'h0;
		end else begin
			state_store_pulse <= cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_STORE); // RQ1
			if (cmd_wr && cmd_hit(wb_dat_i, `TSC_CMD_STORE) && store_cnt_q != 16'hffff)
				store_cnt_q <= store_cnt_q + 16'h1;
		end
	end

	// internal triggers from voltage crossings; current level and hysteresis stay 0, so that detector never fires
	tsc_edge_detect u_det_volt (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.clr       (acq_q != TSC_WAIT),
		.smp_valid (meas_valid),
		.smp       (meas_volt),
		.level     (lvl_volt_q),
		.hyst      (hyst_volt_q),
		.slope     (tsc_slope_t'(slope_q)),
		.fire      (int_fire_v)
	);
	tsc_edge_detect u_det_curr (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.clr       (acq_q != TSC_WAIT),
		.smp_valid (meas_valid),
		.smp       (meas_curr),
		.level     (lvl_curr_q),
		.hyst      (hyst_curr_q),
		.slope     (tsc_slope_t'(slope_q)),
		.fire      (int_fire_c)
	);
endmodule // tsc_trigger_ctrl

// ==== tsc_trigger_ctrl_props.sv ====
// port checker for the trigger control block
// assumes classic wishbone writes with sel all ones from the controller
`timescale 1ns/1ps
`include "tsc_map.svh"
module tsc_props_chk
	import tsc_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [15:0] out_curr_level,
	input wire logic [15:0] out_volt_level,
	input wire logic        waiting_for_trigger_flag,
	input wire logic        err_push,
	input wire logic [15:0] err_code,
	input wire logic        state_store_pulse
);
	logic tk, cw, cont_q, tw_q, st_q;
	// write taken at this edge, and the command register case
	assign tk = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign cw = tk && wb_adr_i == 8'h00;
	// shadow of the continuous bit; the reset command clears config
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			cont_q <= 1'b0;
		else if (tk && wb_adr_i == 8'h04)
			cont_q <= wb_dat_i[0];
		else if (cw && wb_dat_i[6])
			cont_q <= 1'b0;
	end
	// commands and immediate writes that may move the applied levels, and stores
	always_ff @(posedge sys_clk) begin
		tw_q <= rst_n && ((cw && (wb_dat_i & 32'h000000e8) != 32'h0)
			|| (tk && (wb_adr_i == 8'h14 || wb_adr_i == 8'h18)));
		st_q <= rst_n && cw && wb_dat_i[9];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_abort_clr;
		cw && wb_dat_i == 32'h1 && !cont_q |-> ##[1:3] !waiting_for_trigger_flag;
	endproperty
	a_abort_clr: assert property (p_abort_clr) else $error("abort left flag set");
	property p_abort_rearm;
		cw && wb_dat_i == 32'h1 && cont_q |-> ##[1:4] waiting_for_trigger_flag[*2];
	endproperty
	a_abort_rearm: assert property (p_abort_rearm) else $error("no rearm after abort");
	property p_ignore;
		cw && wb_dat_i == 32'h8 && !waiting_for_trigger_flag && !cont_q
			|=> ($stable(out_curr_level) && $stable(out_volt_level))[*3];
	endproperty
	a_ignore: assert property (p_ignore) else $error("idle trigger moved levels");
	property p_apply;
		$changed(out_curr_level) || $changed(out_volt_level) |-> $past(tw_q) || $past(tw_q, 2);
	endproperty
	a_apply: assert property (p_apply) else $error("levels moved without trigger");
	property p_rearm;
		cw && wb_dat_i == 32'h8 && cont_q |-> ##4 waiting_for_trigger_flag;
	endproperty
	a_rearm: assert property (p_rearm) else $error("flag not set after trigger");
	property p_err_code;
		err_push |-> err_code == `TSC_ERR_CODE;
	endproperty
	a_err_code: assert property (p_err_code) else $error("bad self-test code");
	property p_reset_cmd;
		cw && wb_dat_i == 32'h40 |-> ##[1:3] !waiting_for_trigger_flag ##1 !waiting_for_trigger_flag;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset left flag set");
	property p_store;
		state_store_pulse |-> (st_q || $past(st_q)) ##1 !state_store_pulse;
	endproperty
	a_store: assert property (p_store) else $error("stray store pulse");
	cover property (err_push);
	cover property (cw && wb_dat_i == 32'h1 && cont_q);
	cover property ($changed(out_volt_level));
endmodule // tsc_props_chk
bind tsc_trigger_ctrl tsc_props_chk chk_u (.*);

// ==== tsc_host_model.sv ====
// controller model: classic wishbone master issuing commands
// assumes the slave answers every mapped access with ack or err
`timescale 1ns/1ps
module tsc_host_model (
	input  wire logic        sys_clk,
	input  wire logic        wb_ack_o,
	input  wire logic        wb_err_o,
	input  wire logic [31:0] wb_dat_o,
	output logic             wb_cyc_i,
	output logic             wb_stb_i,
	output logic             wb_we_i,
	output logic      [7:0]  wb_adr_i,
	output logic      [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_i
);
	int stores = 0;
	// bus idle from time zero
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'hff;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
	end
	// one cycle, held until the answer is sampled at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		if (w && a == 8'h00 && d[9])
			stores++;
		do @(posedge sys_clk); while (!wb_ack_o && !wb_err_o);
		q = wb_dat_o;
		e = wb_err_o;
		// released lines show inverted values so stale data is never trusted
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= ~w;
		wb_adr_i <= ~a;
		wb_dat_i <= ~d;
	endtask
endmodule // tsc_host_model

// ==== test_trigger_sequence_control.sv ====
// self-checking bench for the trigger control block
// assumes the host model drives the bus and the bench the front end
`timescale 1ns/1ps
module test_trigger_sequence_control;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        meas_valid = 1'b0;
	logic [15:0] meas_volt = 16'h0;
	logic [15:0] meas_curr = 16'h0;
	logic        selftest_fail = 1'b0;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [15:0] out_curr_level, out_volt_level, err_code;
	logic        waiting_for_trigger_flag, err_push, state_store_pulse;
	int          fail_count = 0;
	int          compares = 0;
	int          cycles = 0;
	tsc_trigger_ctrl dut_u (.*);
	tsc_host_model host_u (.*);
	// 100 MHz clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard, well above the length of all tests
	initial begin
		forever begin
			@(posedge sys_clk);
			cycles++;
			if (cycles == 20000) begin
				fail_count++;
				finish_test;
			end
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		host_u.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		host_u.xfer(1'b0, a, 32'h0, q, e);
		chk(n, x, q & m);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one front-end sample; lines inverted once the strobe drops
	task automatic smp(input logic [15:0] v, input logic [15:0] c);
		@(posedge sys_clk);
		meas_valid <= 1'b1;
		meas_volt <= v;
		meas_curr <= c;
		@(posedge sys_clk);
		meas_valid <= 1'b0;
		meas_volt <= ~v;
		meas_curr <= ~c;
	endtask
	task automatic t_rst;
		logic [31:0] q;
		logic        e;
		rdc("cnt curr", 8'h1c, 32'hff, 32'h1);
		rdc("cnt volt", 8'h20, 32'hff, 32'h1);
		rdc("acq cfg", 8'h24, 32'h7, 32'h0);
		rdc("stat", 8'h08, 32'h7, 32'h0);
		host_u.xfer(1'b0, 8'h30, 32'h0, q, e);
		chk("unmapped err", 32'h1, e);
		$display("test reset done");
	endtask
	task automatic t_tran;
		wr(8'h0c, 32'h0123);
		wr(8'h10, 32'h0456);
		wr(8'h00, 32'h8);
		w(3);
		chk("idle trig", 32'h0, out_curr_level);
		wr(8'h00, 32'h2);
		w(3);
		chk("flag armed", 32'h1, waiting_for_trigger_flag);
		wr(8'h00, 32'h8);
		w(3);
		chk("curr", 32'h0123, out_curr_level);
		chk("volt", 32'h0456, out_volt_level);
		chk("flag done", 32'h0, waiting_for_trigger_flag);
		wr(8'h0c, 32'h0321);
		wr(8'h00, 32'h8);
		w(3);
		chk("no rearm", 32'h0123, out_curr_level);
		$display("test transient done");
	endtask
	task automatic t_abort;
		wr(8'h14, 32'h11);
		wr(8'h18, 32'h22);
		wr(8'h00, 32'h400);
		w(3);
		chk("init by name", 32'h1, waiting_for_trigger_flag);
		wr(8'h00, 32'h1);
		w(3);
		chk("abort flag", 32'h0, waiting_for_trigger_flag);
		wr(8'h00, 32'h2);
		wr(8'h00, 32'h20);
		w(3);
		chk("abort curr", 32'h11, out_curr_level);
		chk("abort volt", 32'h22, out_volt_level);
		wr(8'h00, 32'h2);
		wr(8'h00, 32'h80);
		w(3);
		chk("recall flag", 32'h0, waiting_for_trigger_flag);
		$display("test abort done");
	endtask
	task automatic t_cont;
		wr(8'h0c, 32'h0555);
		wr(8'h04, 32'h1);
		w(3);
		chk("cont armed", 32'h1, waiting_for_trigger_flag);
		wr(8'h00, 32'h8);
		w(4);
		chk("cont curr", 32'h0555, out_curr_level);
		chk("cont rearm", 32'h1, waiting_for_trigger_flag);
		wr(8'h00, 32'h1);
		w(4);
		chk("abort rearm", 32'h1, waiting_for_trigger_flag);
		wr(8'h1c, 32'h5);
		wr(8'h00, 32'h40);
		w(4);
		chk("reset flag", 32'h0, waiting_for_trigger_flag);
		rdc("reset cnt", 8'h1c, 32'hff, 32'h1);
		$display("test continuous done");
	endtask
	task automatic t_acq;
		wr(8'h24, 32'h1);
		wr(8'h1c, 32'h65);
		rdc("cnt over", 8'h1c, 32'hff, 32'h1);
		wr(8'h1c, 32'h2);
		wr(8'h20, 32'h64);
		rdc("cnt max", 8'h20, 32'hff, 32'h64);
		wr(8'h20, 32'h3);
		wr(8'h00, 32'h10);
		smp(16'h0bad, 16'h0bad);
		rdc("idle acq", 8'h28, 32'h7f, 32'h0);
		wr(8'h00, 32'h4);
		wr(8'h00, 32'h2);
		wr(8'h00, 32'h8);
		w(3);
		chk("or flag", 32'h1, waiting_for_trigger_flag);
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, 32'h20);
			smp(16'h1000 + 16'(i), 16'h2000 + 16'(i));
			w(3);
			chk("acq flag", {31'h0, i < 2}, waiting_for_trigger_flag);
		end
		rdc("acq count", 8'h28, 32'h7f, 32'h3);
		wr(8'h28, 32'h0);
		rdc("acq word", 8'h2c, 32'hffffffff, 32'h10002000);
		// internal source: level 0x100, band 0xf0..0x110, rising slope
		wr(8'h1c, 32'h1);
		wr(8'h20, 32'h1);
		wr(8'h24, 32'h01002006);
		rdc("slope 3", 8'h24, 32'h7, 32'h0);
		wr(8'h24, 32'h01002002);
		wr(8'h00, 32'h4);
		wr(8'h00, 32'h20);
		smp(16'h0200, 16'h0);
		smp(16'h0000, 16'h0);
		smp(16'h0200, 16'h0);
		smp(16'h0300, 16'h0);
		w(3);
		rdc("int count", 8'h28, 32'h7f, 32'h1);
		rdc("int word", 8'h2c, 32'hffffffff, 32'h03000000);
		chk("int flag", 32'h0, waiting_for_trigger_flag);
		$display("test acquire done");
	endtask
	task automatic t_test;
		logic seen;
		seen = 1'b0;
		selftest_fail <= 1'b1;
		wr(8'h00, 32'h100);
		repeat (60) begin
			@(posedge sys_clk);
			if (err_push === 1'b1)
				seen = 1'b1;
		end
		chk("err push", 32'h1, seen);
		rdc("test fail", 8'h08, 32'h18, 32'h18);
		selftest_fail <= 1'b0;
		wr(8'h00, 32'h100);
		w(40);
		rdc("test pass", 8'h08, 32'h18, 32'h10);
		wr(8'h00, 32'h200);
		w(3);
		rdc("stores", 8'h08, 32'hffff0000, 32'(host_u.stores) << 16);
		$display("test selftest done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_rst;
		t_tran;
		t_abort;
		t_cont;
		t_acq;
		t_test;
		finish_test;
	end
endmodule // test_trigger_sequence_control
